/* bench/gcr_pm_model.sv */
module gcr_pm_model #(
   parameter int DB_HALF = 4
) (
   // Clock and reset
   input  wire logic CLK_SYS,
   input  wire logic SYS_RST,
   // Bench control
   input  wire logic want_idle,
   input  wire logic db_run,
   // Bank sideband
   input  wire logic IDLE_ACK,
   input  wire logic WAKEUP_REQUEST_OUT,
   output logic      IDLE_REQUEST,
   output logic      BANK_CLOCK_ENABLE,
   output logic      DEBOUNCE_CLOCK_IN
);
   timeunit 1ns;
   timeprecision 1ps;

   logic       woke;
   logic       go;
   logic [7:0] db_cnt;

   // -------------------------------------------------------------------
   // Idle handshake
   // -------------------------------------------------------------------
   assign go = want_idle && !woke && !WAKEUP_REQUEST_OUT;

   // Woken bank is not asked again until the bench lets go
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST || !want_idle) begin
         woke <= 1'b0;
      end else if (WAKEUP_REQUEST_OUT) begin
         woke <= 1'b1;
      end
   end

   // Clock is stopped only once the bank has acknowledged
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         IDLE_REQUEST      <= 1'b0;
         BANK_CLOCK_ENABLE <= 1'b1;
      end else begin
         IDLE_REQUEST      <= go;
         BANK_CLOCK_ENABLE <= !(go && IDLE_ACK);
      end
   end

   // -------------------------------------------------------------------
   // Debounce clock
   // -------------------------------------------------------------------
   // Far faster than 32 kHz to keep the run short; stands still when gated
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST || !db_run) begin
         db_cnt            <= 8'h00;
         DEBOUNCE_CLOCK_IN <= 1'b0;
      end else if (db_cnt == 8'(DB_HALF - 1)) begin
         db_cnt            <= 8'h00;
         DEBOUNCE_CLOCK_IN <= !DEBOUNCE_CLOCK_IN;
      end else begin
         db_cnt <= db_cnt + 8'h01;
      end
   end

endmodule : gcr_pm_model

/* bench/tb.sv */
module tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk, sys_rst, dom_rst_n, want_idle, db_run, dbclk;
   logic idle_req, clk_en, ack, wake;
   logic psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, pins, rdata, keep;
   logic        rerr;
   int          bad_count, n_checks, cyc;
   gcr_pkg::gcr_policy_t pols [3];

   gcr_bank_ctrl #(.PINS(32)) DUT (
      .CLK_SYS(clk), .SYS_RST(sys_rst), .ALWAYS_ON_DOMAIN_RESET_N(dom_rst_n),
      .DEBOUNCE_CLOCK_IN(dbclk), .PIN_IN(pins), .IDLE_REQUEST(idle_req),
      .BANK_CLOCK_ENABLE(clk_en), .IDLE_ACK(ack), .WAKEUP_REQUEST_OUT(wake),
      .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
      .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));

   gcr_pm_model #(.DB_HALF(4)) PM (
      .CLK_SYS(clk), .SYS_RST(sys_rst), .want_idle(want_idle), .db_run(db_run),
      .IDLE_ACK(ack), .WAKEUP_REQUEST_OUT(wake), .IDLE_REQUEST(idle_req),
      .BANK_CLOCK_ENABLE(clk_en), .DEBOUNCE_CLOCK_IN(dbclk));

   // -------------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------------
   always #5 clk = ~clk;

   // Hang guard well above the expected run of about 1200 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         bad_count++;
         print_verdict();
      end
   end

   task print_verdict();
      $display("checks=%0d mismatches=%0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : print_verdict

   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // One APB transfer; result left in rdata and rerr
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Waits as long as the slave stalls; the cycle ceiling ends a hang
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rdata = prdata;
      rerr  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task wait_done();
      repeat (4) @(posedge clk);
      for (int i = 0; i < 40; i++) begin
         apb(1'b0, gcr_pkg::OFS_SYSSTATUS, 32'h0);
         if (rdata[0] === 1'b1) break;
      end
   endtask : wait_done

   task wait_sig(input bit wk, input logic v, input int n);
      for (int i = 0; i < n; i++) begin
         if ((wk ? wake : ack) === v) break;
         @(posedge clk);
      end
   endtask : wait_sig

   task settle();
      repeat (60) @(posedge clk);
   endtask : settle

   // Expectations per idle policy
   function automatic logic [31:0] exp_mode(input gcr_pkg::gcr_policy_t p);
      if (p == gcr_pkg::GCR_POL_FORCE) return {29'h0, gcr_pkg::GCR_INACTIVE};
      if (p == gcr_pkg::GCR_POL_SMART) return {29'h0, gcr_pkg::GCR_IDLE};
      return {29'h0, gcr_pkg::GCR_ACTIVE};
   endfunction : exp_mode

   // -------------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------------
   initial begin
      clk = 1'b0;
      sys_rst = 1'b1;
      dom_rst_n = 1'b1;
      want_idle = 1'b0;
      db_run = 1'b1;
      pins = 32'h0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      pols = '{gcr_pkg::GCR_POL_FORCE, gcr_pkg::GCR_POL_NONE, gcr_pkg::GCR_POL_SMART};
      void'($urandom(32'h38fc));
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      wait_done();
      chk("reset done", {31'h0, rdata[0]}, 32'h1);
      apb(1'b0, gcr_pkg::OFS_SYSCONFIG, 32'h0);
      chk("config reset", rdata, 32'h0);
      // Software reset: bit reads 1, done flag low, then both settle
      apb(1'b1, gcr_pkg::OFS_DEBOUNCE, 32'h5);
      apb(1'b1, gcr_pkg::OFS_SYSCONFIG, 32'h2);
      apb(1'b0, gcr_pkg::OFS_SYSCONFIG, 32'h0);
      chk("soft bit busy", rdata & 32'h2, 32'h2);
      apb(1'b0, gcr_pkg::OFS_SYSSTATUS, 32'h0);
      chk("done in soft", rdata & 32'h1, 32'h0);
      wait_done();
      chk("done after soft", rdata & 32'h1, 32'h1);
      apb(1'b0, gcr_pkg::OFS_SYSCONFIG, 32'h0);
      chk("soft bit clear", rdata, 32'h0);
      apb(1'b0, gcr_pkg::OFS_DEBOUNCE, 32'h0);
      chk("soft clears cfg", rdata, 32'h0);
      // Domain reset clears configuration too
      apb(1'b1, gcr_pkg::OFS_DEBOUNCE, 32'h3);
      dom_rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      dom_rst_n <= 1'b1;
      wait_done();
      apb(1'b0, gcr_pkg::OFS_DEBOUNCE, 32'h0);
      chk("domain reset", rdata, 32'h0);
      apb(1'b0, 12'hFFC, 32'h0);
      chk("unmapped err", {31'h0, rerr}, 32'h1);
      // Random capture through the filter
      for (int i = 0; i < 4; i++) begin
         pins <= $urandom;
         settle();
         apb(1'b0, gcr_pkg::OFS_DATAIN, 32'h0);
         chk("datain", rdata, pins);
      end
      // Stopped debounce clock blocks inputs
      keep = pins;
      db_run <= 1'b0;
      // Let a tick already in the synchroniser pass before the pins move
      repeat (4) @(posedge clk);
      pins <= ~pins;
      settle();
      apb(1'b0, gcr_pkg::OFS_DATAIN, 32'h0);
      chk("db stopped", rdata, keep);
      db_run <= 1'b1;
      settle();
      // Events in active mode
      apb(1'b1, gcr_pkg::OFS_EVT_ENABLE, 32'h1);
      apb(1'b1, gcr_pkg::OFS_EVT_STATUS, 32'hFFFFFFFF);
      pins[0] <= ~pins[0];
      settle();
      apb(1'b0, gcr_pkg::OFS_EVT_STATUS, 32'h0);
      chk("active event", rdata & 32'h1, 32'h1);
      apb(1'b1, gcr_pkg::OFS_EVT_STATUS, 32'hFFFFFFFF);
      // Module gate: disabled mode, no events
      apb(1'b1, gcr_pkg::OFS_CTRL, 32'h1);
      apb(1'b0, gcr_pkg::OFS_MODE, 32'h0);
      chk("gated mode", rdata & 32'h7, {29'h0, gcr_pkg::GCR_DISABLED});
      pins[0] <= ~pins[0];
      settle();
      apb(1'b0, gcr_pkg::OFS_EVT_STATUS, 32'h0);
      chk("gated event", rdata, 32'h0);
      apb(1'b1, gcr_pkg::OFS_CTRL, 32'h0);
      apb(1'b0, gcr_pkg::OFS_MODE, 32'h0);
      chk("ungated mode", rdata & 32'h7, 32'h0);
      settle();
      apb(1'b1, gcr_pkg::OFS_EVT_STATUS, 32'hFFFFFFFF);
      // Each idle policy with wake-up allowed
      foreach (pols[k]) begin
         apb(1'b1, gcr_pkg::OFS_SYSCONFIG, {27'h0, pols[k], 1'b1, 2'b00});
         want_idle <= 1'b1;
         wait_sig(1'b0, pols[k] != gcr_pkg::GCR_POL_NONE, 40);
         repeat (5) @(posedge clk);
         chk("ack", {31'h0, ack}, {31'h0, pols[k] != gcr_pkg::GCR_POL_NONE});
         apb(1'b0, gcr_pkg::OFS_MODE, 32'h0);
         chk("idle mode", rdata & 32'h7, exp_mode(pols[k]));
         pins[0] <= ~pins[0];
         wait_sig(1'b1, 1'b1, 60);
         chk("wake", {31'h0, wake}, {31'h0, pols[k] == gcr_pkg::GCR_POL_SMART});
         apb(1'b0, gcr_pkg::OFS_EVT_STATUS, 32'h0);
         chk("idle event", rdata, {31'h0, pols[k] == gcr_pkg::GCR_POL_NONE});
         want_idle <= 1'b0;
         wait_sig(1'b0, 1'b0, 40);
         repeat (3) @(posedge clk);
         apb(1'b0, gcr_pkg::OFS_MODE, 32'h0);
         chk("back active", rdata & 32'h37, 32'h0);
         settle();
         apb(1'b1, gcr_pkg::OFS_EVT_STATUS, 32'hFFFFFFFF);
      end
      // Smart idle held off by pending status, no wake when not allowed
      apb(1'b1, gcr_pkg::OFS_SYSCONFIG, {27'h0, gcr_pkg::GCR_POL_SMART, 3'b000});
      pins[0] <= ~pins[0];
      settle();
      want_idle <= 1'b1;
      repeat (30) @(posedge clk);
      chk("pending no ack", {31'h0, ack}, 32'h0);
      apb(1'b1, gcr_pkg::OFS_EVT_STATUS, 32'hFFFFFFFF);
      wait_sig(1'b0, 1'b1, 40);
      chk("ack after clear", {31'h0, ack}, 32'h1);
      pins[0] <= ~pins[0];
      settle();
      chk("wake disallowed", {31'h0, wake}, 32'h0);
      want_idle <= 1'b0;
      wait_sig(1'b0, 1'b0, 40);
      chk("ack drop", {31'h0, ack}, 32'h0);
      print_verdict();
   end

endmodule : tb

/* rtl/gcr_bank_ctrl.sv */
module gcr_bank_ctrl #(
   parameter int PINS = 32
) (
   // Clock and reset
   input  wire logic              CLK_SYS,
   input  wire logic              SYS_RST,
   input  wire logic              ALWAYS_ON_DOMAIN_RESET_N,
   // Debounce clock and pins
   input  wire logic              DEBOUNCE_CLOCK_IN,
   input  wire logic [PINS-1:0]   PIN_IN,
   // Power manager sideband
   input  wire logic              IDLE_REQUEST,
   input  wire logic              BANK_CLOCK_ENABLE,
   output logic                   IDLE_ACK,
   output logic                   WAKEUP_REQUEST_OUT,
   // APB slave
   input  wire logic              PSEL,
   input  wire logic              PENABLE,
   input  wire logic              PWRITE,
   input  wire logic [11:0]       PADDR,
   input  wire logic [31:0]       PWDATA,
   output logic      [31:0]       PRDATA,
   output logic                   PREADY,
   output logic                   PSLVERR
);

   // Elaboration check: the read path holds at most one word of pins
   if (PINS < 1 || PINS > 32) begin : g_bad_pins
      $error("gcr_bank_ctrl: PINS must be 1..32");
   end

   // -------------------------------------------------------------------
   // Synchronisers for pins and sideband
   // -------------------------------------------------------------------
   logic [PINS-1:0] pin_s1, pin_s2;
   logic [3:0]      sb_s1, sb_s2;
   logic            dbclk_d;
   always_ff @(posedge CLK_SYS) begin
      pin_s1 <= PIN_IN;
      pin_s2 <= pin_s1;
      sb_s1  <= {ALWAYS_ON_DOMAIN_RESET_N, DEBOUNCE_CLOCK_IN, IDLE_REQUEST, BANK_CLOCK_ENABLE};
      sb_s2  <= sb_s1;
      dbclk_d <= sb_s2[2];
   end

   logic hw_rst, idle_req, clk_en, db_tick;
   assign hw_rst   = SYS_RST | ~sb_s2[3];
   assign idle_req = sb_s2[1];
   assign clk_en   = sb_s2[0];
   assign db_tick  = sb_s2[2] & ~dbclk_d;          // rising edge of debounce clock

   // -------------------------------------------------------------------
   // Reset sequencing
   // -------------------------------------------------------------------
   logic [3:0] rst_cnt;
   logic       soft_active;
   logic       reset_done;
   logic       in_reset;
   logic       apb_wr, apb_rd_setup;
   assign in_reset     = (rst_cnt != 4'h0);
   assign apb_wr       = PSEL & PENABLE & PWRITE;
   assign apb_rd_setup = PSEL & ~PENABLE & ~PWRITE;

   // Counter survives its own soft reset so the sequence can finish
   always_ff @(posedge CLK_SYS) begin
      if (hw_rst) begin
         rst_cnt     <= gcr_pkg::RESET_CYCLES;
         soft_active <= 1'b0;
      end else if (apb_wr && PADDR == gcr_pkg::OFS_SYSCONFIG
                   && PWDATA[gcr_pkg::SC_SOFT_RESET_BIT] && !in_reset) begin
         rst_cnt     <= gcr_pkg::RESET_CYCLES;
         soft_active <= 1'b1;
      end else if (in_reset) begin
         rst_cnt     <= rst_cnt - 4'h1;
         if (rst_cnt == 4'h1) soft_active <= 1'b0;
      end
   end

   // Flag follows the sequence one cycle late, still high in the first cycle of a soft reset
   always_ff @(posedge CLK_SYS) begin
      if (hw_rst) reset_done <= 1'b0;
      else        reset_done <= ~in_reset;
   end

   logic lrst;
   assign lrst = hw_rst | in_reset;                // same effect as hardware reset

   // -------------------------------------------------------------------
   // Configuration registers
   // -------------------------------------------------------------------
   logic                     autoidle, wake_allow, module_gate;
   gcr_pkg::gcr_policy_t     policy;
   logic [PINS-1:0]          evt_enable;
   logic [7:0]               db_time, db_live;
   logic                     db_pend;

   always_ff @(posedge CLK_SYS) begin
      if (lrst) begin
         autoidle    <= 1'b0;
         wake_allow  <= 1'b0;
         policy      <= gcr_pkg::gcr_policy_t'(gcr_pkg::IDLE_POLICY_RST);
         module_gate <= 1'b0;
         evt_enable  <= '0;
         db_time     <= gcr_pkg::DEBOUNCE_RST;
      end else if (apb_wr) begin
         unique case (PADDR)
            gcr_pkg::OFS_SYSCONFIG: begin
               autoidle   <= PWDATA[gcr_pkg::SC_AUTOIDLE_BIT];
               wake_allow <= PWDATA[gcr_pkg::SC_WAKEUP_ALLOW];
               policy     <= gcr_pkg::gcr_policy_t'(
                                PWDATA[gcr_pkg::SC_IDLE_POLICY_LO +: 2]);
            end
            gcr_pkg::OFS_CTRL:       module_gate <= PWDATA[gcr_pkg::CTRL_MODULE_GATE];
            gcr_pkg::OFS_EVT_ENABLE: evt_enable  <= PWDATA[PINS-1:0];
            gcr_pkg::OFS_DEBOUNCE:   db_time     <= PWDATA[7:0];
            default: ;
         endcase
      end
   end

   // Debounce time crosses to the filter only on a tick; pending until then
   always_ff @(posedge CLK_SYS) begin
      if (lrst) begin
         db_live <= gcr_pkg::DEBOUNCE_RST;
         db_pend <= 1'b0;
      end else if (apb_wr && PADDR == gcr_pkg::OFS_DEBOUNCE) begin
         db_pend <= 1'b1;
      end else if (db_tick) begin
         db_live <= db_time;
         db_pend <= 1'b0;
      end
   end

   // -------------------------------------------------------------------
   // Mode machine and local clock gating
   // -------------------------------------------------------------------
   gcr_pkg::gcr_mode_t mode, next_mode;
   logic run_en, filt_en;
   logic [PINS-1:0] filt, datain, evt_status, edge_hit;
   logic capture_done, status_clear;

   // Filter runs in active and idle only; idle keeps it alive for wake-up detection
   assign run_en  = (mode == gcr_pkg::GCR_ACTIVE);
   assign filt_en = (mode == gcr_pkg::GCR_ACTIVE) || (mode == gcr_pkg::GCR_IDLE);
   assign capture_done = (datain == filt);

   always_comb begin
      next_mode = mode;
      unique case (mode)
         gcr_pkg::GCR_ACTIVE: begin
            if (module_gate) next_mode = gcr_pkg::GCR_DISABLED;
            else if (idle_req) begin
               if (policy == gcr_pkg::GCR_POL_SMART && capture_done
                   && evt_status == '0 && !db_pend)
                  next_mode = gcr_pkg::GCR_IDLE;
               else if (policy == gcr_pkg::GCR_POL_FORCE)
                  next_mode = gcr_pkg::GCR_INACTIVE;
            end
         end
         gcr_pkg::GCR_IDLE, gcr_pkg::GCR_INACTIVE: begin
            if (!idle_req && clk_en) next_mode = gcr_pkg::GCR_ACTIVE;
         end
         gcr_pkg::GCR_DISABLED: begin
            if (!module_gate) next_mode = gcr_pkg::GCR_ACTIVE;
         end
         default: next_mode = gcr_pkg::GCR_ACTIVE;
      endcase
   end

   always_ff @(posedge CLK_SYS) begin
      if (lrst) mode <= gcr_pkg::GCR_ACTIVE;
      else      mode <= next_mode;
   end

   // -------------------------------------------------------------------
   // Debounce filter, one stability counter per pin
   // -------------------------------------------------------------------
   logic [7:0] stab [PINS];
   always_ff @(posedge CLK_SYS) begin
      if (lrst) begin
         filt <= '0;
         for (int i = 0; i < PINS; i++) stab[i] <= 8'h00;
      end else if (db_tick && filt_en) begin       // no tick means blocked
         for (int i = 0; i < PINS; i++) begin
            if (pin_s2[i] == filt[i]) stab[i] <= 8'h00;
            else if (stab[i] >= db_live) begin
               filt[i] <= pin_s2[i];
               stab[i] <= 8'h00;
            end else stab[i] <= stab[i] + 8'h01;
         end
      end
   end

   // Capture only while running; edge detection in active and idle
   logic [PINS-1:0] filt_prev;
   always_ff @(posedge CLK_SYS) begin
      if (lrst) begin
         datain    <= '0;
         filt_prev <= '0;
      end else if (filt_en) begin
         if (run_en) datain <= filt;
         filt_prev <= filt;
      end
   end
   assign edge_hit = (filt ^ filt_prev) & evt_enable;

   // Event status: set wins over a same-cycle clear
   assign status_clear = apb_wr && PADDR == gcr_pkg::OFS_EVT_STATUS;
   always_ff @(posedge CLK_SYS) begin
      if (lrst) evt_status <= '0;
      else begin
         evt_status <= (evt_status & ~(status_clear ? PWDATA[PINS-1:0] : '0))
                       | (run_en ? edge_hit : '0);
      end
   end

   // -------------------------------------------------------------------
   // Sideband outputs
   // -------------------------------------------------------------------
   always_ff @(posedge CLK_SYS) begin
      if (lrst) begin
         IDLE_ACK           <= 1'b0;
         WAKEUP_REQUEST_OUT <= 1'b0;
      end else begin
         IDLE_ACK <= (next_mode == gcr_pkg::GCR_IDLE)
                   || (next_mode == gcr_pkg::GCR_INACTIVE);
         if (mode != gcr_pkg::GCR_IDLE) WAKEUP_REQUEST_OUT <= 1'b0;
         else if (wake_allow && edge_hit != '0)
            WAKEUP_REQUEST_OUT <= 1'b1;
      end
   end

   // -------------------------------------------------------------------
   // APB read path: sampled in setup, valid through access
   // -------------------------------------------------------------------
   logic [31:0] rd_word;
   logic        rd_hit;
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_hit  = 1'b1;
      unique case (PADDR)
         gcr_pkg::OFS_SYSCONFIG: begin
            rd_word[gcr_pkg::SC_AUTOIDLE_BIT]        = autoidle;
            rd_word[gcr_pkg::SC_SOFT_RESET_BIT]      = soft_active;
            rd_word[gcr_pkg::SC_WAKEUP_ALLOW]        = wake_allow;
            rd_word[gcr_pkg::SC_IDLE_POLICY_LO +: 2] = policy;
         end
         gcr_pkg::OFS_SYSSTATUS:  rd_word[gcr_pkg::SS_RESET_DONE_BIT] = reset_done;
         gcr_pkg::OFS_EVT_STATUS: rd_word[PINS-1:0] = evt_status;
         gcr_pkg::OFS_EVT_ENABLE: rd_word[PINS-1:0] = evt_enable;
         gcr_pkg::OFS_CTRL:       rd_word[gcr_pkg::CTRL_MODULE_GATE] = module_gate;
         gcr_pkg::OFS_DATAIN:     rd_word[PINS-1:0] = datain;
         gcr_pkg::OFS_DEBOUNCE:   rd_word[7:0] = db_time;
         gcr_pkg::OFS_MODE: begin
            rd_word[2:0]                        = mode;
            rd_word[gcr_pkg::MODE_ACK_BIT]      = IDLE_ACK;
            rd_word[gcr_pkg::MODE_WAKE_BIT]     = WAKEUP_REQUEST_OUT;
            rd_word[gcr_pkg::MODE_DB_PEND_BIT]  = db_pend;
         end
         default: rd_hit = 1'b0;
      endcase
   end

   logic rd_err;
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         PRDATA <= 32'h0000_0000;
         rd_err <= 1'b0;
      end else if (PSEL && !PENABLE) begin
         PRDATA <= apb_rd_setup ? rd_word : 32'h0000_0000;
         rd_err <= ~rd_hit;
      end
   end

   // Zero wait states; unmapped addresses answer with an error
   assign PREADY  = 1'b1;
   assign PSLVERR = PSEL & PENABLE & rd_err;

   // -------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (SYS_RST);

   a_done_low_reset: assert property (in_reset |=> !reset_done)
      else $error("reset complete flag high during reset");
   a_done_after_seq: assert property ($fell(in_reset) |=> reset_done)
      else $error("reset complete flag not set after reset");
   a_soft_clears: assert property ($rose(soft_active) |-> ##8 !soft_active)
      else $error("software reset bit did not clear in time");
   a_soft_resets_cfg: assert property ($rose(soft_active) |=> module_gate == 1'b0)
      else $error("software reset left configuration");
   a_noidle_no_ack: assert property (policy == gcr_pkg::GCR_POL_NONE
      && !IDLE_ACK |=> !IDLE_ACK)
      else $error("acknowledge under no-idle policy");
   // Watches the mode register itself, so a broken entry decode is caught
   a_smart_guard: assert property ($rose(mode == gcr_pkg::GCR_IDLE)
      |-> $past(evt_status) == '0 && !$past(db_pend)
          && $past(policy) == gcr_pkg::GCR_POL_SMART)
      else $error("smart idle entered with work pending");
   a_entry_on_req: assert property (mode == gcr_pkg::GCR_ACTIVE && !idle_req
      |=> mode != gcr_pkg::GCR_IDLE && mode != gcr_pkg::GCR_INACTIVE)
      else $error("idle entered without request");
   a_wake_idle_only: assert property (WAKEUP_REQUEST_OUT
      |-> $past(mode) == gcr_pkg::GCR_IDLE && wake_allow)
      else $error("wake-up outside idle or not allowed");
   a_no_evt_idle: assert property (mode != gcr_pkg::GCR_ACTIVE
      && !status_clear |=> evt_status == $past(evt_status))
      else $error("event status changed outside active mode");
   a_ack_release: assert property (mode == gcr_pkg::GCR_IDLE && !idle_req
      && clk_en && !lrst |=> !IDLE_ACK)
      else $error("acknowledge not dropped");
   a_gate_freeze: assert property (module_gate
      && mode == gcr_pkg::GCR_DISABLED |=> filt == $past(filt))
      else $error("filter moved while gated");

   c_smart_idle: cover property (mode == gcr_pkg::GCR_ACTIVE ##1 mode == gcr_pkg::GCR_IDLE);
   c_force_idle: cover property (mode == gcr_pkg::GCR_INACTIVE);
   c_wakeup:     cover property ($rose(WAKEUP_REQUEST_OUT));
   c_soft_reset: cover property ($rose(soft_active) ##[1:20] reset_done);

endmodule : gcr_bank_ctrl

/* rtl/gcr_pkg.sv */
package gcr_pkg;

   // -------------------------------------------------------------------
   // Register map (byte addresses, one word each)
   // -------------------------------------------------------------------
   localparam logic [11:0] OFS_SYSCONFIG  = 12'h010;
   localparam logic [11:0] OFS_SYSSTATUS  = 12'h014;
   localparam logic [11:0] OFS_EVT_STATUS = 12'h018;
   localparam logic [11:0] OFS_EVT_ENABLE = 12'h01C;
   localparam logic [11:0] OFS_CTRL       = 12'h030;
   localparam logic [11:0] OFS_DATAIN     = 12'h038;
   localparam logic [11:0] OFS_MODE       = 12'h040;
   localparam logic [11:0] OFS_DEBOUNCE   = 12'h050;

   // -------------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------------
   localparam int SC_AUTOIDLE_BIT    = 0;
   localparam int SC_SOFT_RESET_BIT  = 1;
   localparam int SC_WAKEUP_ALLOW    = 2;
   localparam int SC_IDLE_POLICY_LO  = 3;
   localparam int SS_RESET_DONE_BIT  = 0;
   localparam int CTRL_MODULE_GATE   = 0;
   localparam int MODE_ACK_BIT       = 4;
   localparam int MODE_WAKE_BIT      = 5;
   localparam int MODE_DB_PEND_BIT   = 6;

   // -------------------------------------------------------------------
   // Reset values and counts
   // -------------------------------------------------------------------
   localparam logic [1:0]  IDLE_POLICY_RST = 2'h0;
   localparam logic [7:0]  DEBOUNCE_RST    = 8'h00;
   localparam logic [3:0]  RESET_CYCLES    = 4'h8;

   // Idle policy encodings
   typedef enum logic [1:0] {
      GCR_POL_FORCE = 2'b00,
      GCR_POL_NONE  = 2'b01,
      GCR_POL_SMART = 2'b10,
      GCR_POL_RSVD  = 2'b11
   } gcr_policy_t;

   // Operating modes
   typedef enum logic [2:0] {
      GCR_ACTIVE,
      GCR_IDLE,
      GCR_INACTIVE,
      GCR_DISABLED
   } gcr_mode_t;

endpackage : gcr_pkg
